// ---- hw/adc_frame_ctrl.sv ----
`timescale 1ns/10ps
module adc_frame_ctrl
  import adc_frame_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                reset_n,
  input  wire logic                link_sclk,
  input  wire logic                cs_n,
  input  wire logic                input_channel_select,
  input  wire logic                powerdown_request_pin,
  input  wire logic [RESULT_W-1:0] ch0_code,
  input  wire logic [RESULT_W-1:0] ch1_code,
  output logic                     sdo_out,
  output logic                     sdo_oe,
  output logic                     acquiring,
  output logic                     powered_down,
  output logic                     frame_mode32,
  output logic                     conv_abort,
  output logic [RESULT_W-1:0]      last_result
);

  // ---------------------------------------------------------------
  // link side, clocked by the serial clock
  // ---------------------------------------------------------------

  // chip select high clears all per-frame link state without any clock
  logic frame_rst_n;
  assign frame_rst_n = reset_n & ~cs_n;

  logic                rise_seen_q;
  logic                rise_seen_d;
  logic [CNT_W-1:0]    fall_cnt_q;
  logic [CNT_W-1:0]    fall_cnt_d;
  logic [RESULT_W-1:0] result_q;
  logic [RESULT_W-1:0] result_d;
  logic                done16_tgl_q;
  logic                done16_tgl_d;
  logic                done30_tgl_q;
  logic                done30_tgl_d;
  logic [RESULT_W-1:0] sar_code;
  logic                sar_step;

  // core-side state that the link reads; it settles within a few core
  // cycles of a chip-select edge, long before the first link clock rise
  logic                mode32_q;
  logic [RESULT_W-1:0] sample_q;

  always_comb begin
    rise_seen_d = 1'b1;
  end

  always_ff @(posedge link_sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      rise_seen_q <= 1'b0;
    end else begin
      rise_seen_q <= rise_seen_d;
    end
  end

  // falls before the first rise do not count
  always_comb begin
    fall_cnt_d = fall_cnt_q;
    if (rise_seen_q && fall_cnt_q != CNT_MAX) begin
      fall_cnt_d = fall_cnt_q + 6'h01;
    end
  end

  always_ff @(negedge link_sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      fall_cnt_q <= '0;
    end else begin
      fall_cnt_q <= fall_cnt_d;
    end
  end

  assign sar_step = rise_seen_q && (fall_cnt_q < SAR_STEPS);

  sar_stepper u_sar (
    .link_sclk   (link_sclk),
    .frame_rst_n (frame_rst_n),
    .step        (sar_step),
    .step_idx    (fall_cnt_q),
    .held_sample (sample_q),
    .code        (sar_code)
  );

  // frame-spanning link state, cleared only by reset_n
  always_comb begin
    result_d     = result_q;
    done16_tgl_d = done16_tgl_q;
    done30_tgl_d = done30_tgl_q;
    if (rise_seen_q && fall_cnt_d == CONV_DONE_FALLS && fall_cnt_q != CONV_DONE_FALLS) begin
      result_d     = sar_code;
      done16_tgl_d = ~done16_tgl_q;
    end
    if (rise_seen_q && fall_cnt_d == MODE32_FALLS && fall_cnt_q != MODE32_FALLS) begin
      done30_tgl_d = ~done30_tgl_q;
    end
  end

  always_ff @(negedge link_sclk or negedge reset_n) begin
    if (!reset_n) begin
      result_q     <= RESULT_RST;
      done16_tgl_q <= 1'b0;
      done30_tgl_q <= 1'b0;
    end else begin
      result_q     <= result_d;
      done16_tgl_q <= done16_tgl_d;
      done30_tgl_q <= done30_tgl_d;
    end
  end

  // output word: first half old result or zeros, second half fresh result
  logic [WORD_W-1:0]   first_half;
  logic [2*WORD_W-1:0] frame_word;
  logic                bit_now;

  always_comb begin
    first_half = result_word(result_q);
    if (mode32_q) begin
      first_half = ZERO_WORD;
    end
    frame_word = {first_half, result_word(result_q)};
    bit_now    = 1'b0;
    if (fall_cnt_q < FRAME32_FALLS) begin
      // fall count 0 selects the msb, out as soon as chip select falls
      bit_now = frame_word[5'(FRAME32_FALLS - 6'h01 - fall_cnt_q)];
    end
  end

  assign sdo_oe  = frame_rst_n;
  assign sdo_out = frame_rst_n & bit_now;

  // ---------------------------------------------------------------
  // core side
  // ---------------------------------------------------------------

  logic [4:0] pins_s;
  logic       cs_high_s;
  logic       chsel_s;
  logic       pd_s;
  logic       d16_s;
  logic       d30_s;

  level_sync #(
    .WIDTH (5)
  ) u_sync (
    .clk      (core_clk),
    .reset_n  (reset_n),
    .async_in ({~cs_n, input_channel_select, powerdown_request_pin,
                done16_tgl_q, done30_tgl_q}),
    .sync_out (pins_s)
  );

  // chip select enters inverted so the cleared synchroniser reads as idle
  assign cs_high_s = ~pins_s[4];
  assign chsel_s   = pins_s[3];
  assign pd_s      = pins_s[2];
  assign d16_s     = pins_s[1];
  assign d30_s     = pins_s[0];

  frame_state_t        state_q;
  frame_state_t        state_d;
  logic [1:0]          settle_q;
  logic [1:0]          settle_d;
  logic                d16_seen_q;
  logic                d16_seen_d;
  logic                d30_seen_q;
  logic                d30_seen_d;
  logic                got16_q;
  logic                got16_d;
  logic                got30_q;
  logic                got30_d;
  logic                mode32_d;
  logic [RESULT_W-1:0] sample_d;
  logic                acq_q;
  logic                acq_d;
  logic                pd_armed_q;
  logic                pd_armed_d;
  logic                pwrdn_q;
  logic                pwrdn_d;
  logic                abort_q;
  logic                abort_d;
  logic                ev16;
  logic                ev30;

  assign ev16 = d16_s ^ d16_seen_q;
  assign ev30 = d30_s ^ d30_seen_q;

  always_comb begin
    state_d    = state_q;
    settle_d   = settle_q;
    d16_seen_d = d16_s;
    d30_seen_d = d30_s;
    got16_d    = got16_q | ev16;
    got30_d    = got30_q | ev30;
    mode32_d   = mode32_q;
    sample_d   = sample_q;
    acq_d      = acq_q;
    pd_armed_d = pd_armed_q;
    pwrdn_d    = pwrdn_q;
    abort_d    = 1'b0;
    if (ev16) begin
      acq_d = 1'b1;
      if (pd_armed_q) begin
        pwrdn_d = 1'b1;
      end
    end
    case (state_q)
      FR_IDLE: begin
        if (!cs_high_s) begin
          // chip select fell: hold the selected channel
          sample_d = (chsel_s == CHAN0_PICK) ? ch0_code : ch1_code;
          acq_d    = 1'b0;
          got16_d  = 1'b0;
          got30_d  = 1'b0;
          state_d  = FR_ACTIVE;
        end
      end
      FR_ACTIVE: begin
        if (cs_high_s) begin
          pd_armed_d = pd_s;
          if (!pd_s) begin
            pwrdn_d = 1'b0;
          end
          settle_d = '0;
          state_d  = FR_SETTLE;
        end
      end
      FR_SETTLE: begin
        // lets link events from just before the rise arrive first
        settle_d = settle_q + 2'b01;
        if (settle_q == SETTLE_LAST) begin
          if (got30_d) begin
            mode32_d = 1'b1;
          end else if (got16_d) begin
            mode32_d = 1'b0;
          end else begin
            abort_d = 1'b1;
            acq_d   = 1'b1;
          end
          state_d = FR_IDLE;
        end
      end
      default: begin
        state_d = FR_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q    <= FR_IDLE;
      settle_q   <= '0;
      d16_seen_q <= 1'b0;
      d30_seen_q <= 1'b0;
      got16_q    <= 1'b0;
      got30_q    <= 1'b0;
      mode32_q   <= MODE32_RST;
      sample_q   <= RESULT_RST;
      acq_q      <= 1'b1;
      pd_armed_q <= 1'b0;
      pwrdn_q    <= 1'b0;
      abort_q    <= 1'b0;
    end else begin
      state_q    <= state_d;
      settle_q   <= settle_d;
      d16_seen_q <= d16_seen_d;
      d30_seen_q <= d30_seen_d;
      got16_q    <= got16_d;
      got30_q    <= got30_d;
      mode32_q   <= mode32_d;
      sample_q   <= sample_d;
      acq_q      <= acq_d;
      pd_armed_q <= pd_armed_d;
      pwrdn_q    <= pwrdn_d;
      abort_q    <= abort_d;
    end
  end

  // result is read only after a completed conversion, long after it settled
  logic [RESULT_W-1:0] last_q;
  logic [RESULT_W-1:0] last_d;

  always_comb begin
    last_d = last_q;
    if (state_q == FR_SETTLE && settle_q == SETTLE_LAST && got16_q) begin
      last_d = result_q;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      last_q <= RESULT_RST;
    end else begin
      last_q <= last_d;
    end
  end

  assign acquiring    = acq_q;
  assign powered_down = pwrdn_q;
  assign frame_mode32 = mode32_q;
  assign conv_abort   = abort_q;
  assign last_result  = last_q;

endmodule

// ---- hw/adc_frame_pkg.sv ----
// Summary of operation
// - result is a 14-bit unsigned straight binary code, full scale at reference
// - channel-select low converts channel 0, high converts channel 1
// - two framings exist, 16 or 32 clocks, chosen by chip-select low length
// - in 16-clock framing acquisition starts at the 16th clock fall
// - the input is sampled at the chip-select fall
// - chip-select fall enables data output and drives the msb at once
// - after first clock rise, each later clock fall shifts out the next bit
// - in 16-clock framing the frame carries the previous frame's result
// - conversion runs on the serial clock and completes at the 16th fall
// - chip-select rise after 16th fall, before 32-clock detection, keeps 16-clock framing
// - data output is high impedance whenever chip select is high
// - held low past 16th fall, the fresh result shifts out from that fall
// - chip select low through the 30th fall switches to 32-clock framing
// - after 32-clock detection, the next frame's first 16 bits are zero
// - 32-clock framing outputs the latest sample's result within the same frame
// - chip-select rise within the first 16 clocks aborts and starts acquisition
// - after abort the next frame samples normally, its output data is invalid
// - after abort, frame n+1 sample is delivered in frame n+2
// - power-down pin is sampled only at chip-select rise, host sets it before
package adc_frame_pkg;

  localparam int unsigned RESULT_W       = 14;
  localparam int unsigned WORD_W         = 16;
  localparam int unsigned CNT_W          = 6;

  localparam logic [CNT_W-1:0] CONV_DONE_FALLS = 6'h10;
  localparam logic [CNT_W-1:0] MODE32_FALLS    = 6'h1e;
  localparam logic [CNT_W-1:0] FRAME32_FALLS   = 6'h20;
  localparam logic [CNT_W-1:0] SAR_STEPS       = 6'h0e;
  localparam logic [CNT_W-1:0] CNT_MAX         = 6'h3f;

  localparam logic             CHAN0_PICK      = 1'b0;
  localparam logic             MODE32_RST      = 1'b0;
  localparam logic [RESULT_W-1:0] RESULT_RST   = 14'h0000;
  localparam logic [WORD_W-1:0]   ZERO_WORD    = 16'h0000;

  localparam int unsigned CORE_CLK_PERIOD_NS = 4;
  localparam int unsigned SETTLE_NS          = 8;
  localparam int unsigned SETTLE_CYCLES      = (SETTLE_NS + CORE_CLK_PERIOD_NS - 1)
                                               / CORE_CLK_PERIOD_NS;
  localparam logic [1:0]  SETTLE_LAST        = 2'(SETTLE_CYCLES - 1);

  typedef enum logic [1:0] {FR_IDLE, FR_ACTIVE, FR_SETTLE} frame_state_t;

  // result sits in the top 14 bits, two trailing zero bits fill the word
  function automatic logic [WORD_W-1:0] result_word(input logic [RESULT_W-1:0] r);
    result_word = {r, 2'b00};
  endfunction

endpackage

// ---- hw/level_sync.sv ----
`timescale 1ns/10ps
module level_sync
  import adc_frame_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

// ---- hw/sar_stepper.sv ----
`timescale 1ns/10ps
module sar_stepper
  import adc_frame_pkg::*;
(
  input  wire logic                link_sclk,
  input  wire logic                frame_rst_n,
  input  wire logic                step,
  input  wire logic [CNT_W-1:0]    step_idx,
  input  wire logic [RESULT_W-1:0] held_sample,
  output logic      [RESULT_W-1:0] code
);

  logic [RESULT_W-1:0] code_q;
  logic [RESULT_W-1:0] code_d;

  // one trial bit per clock fall, msb first
  always_comb begin
    logic [RESULT_W-1:0] trial;
    logic [CNT_W-1:0]    pos;
    trial  = code_q;
    pos    = SAR_STEPS - 6'h01 - step_idx;
    code_d = code_q;
    if (step) begin
      trial = code_q | (RESULT_W'(1) << pos);
      if (trial <= held_sample) begin
        code_d = trial;
      end
    end
  end

  always_ff @(negedge link_sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      code_q <= RESULT_RST;
    end else begin
      code_q <= code_d;
    end
  end

  assign code = code_q;

endmodule

// ---- sim/adc_frame_props.sv ----
`timescale 1ns/10ps
module adc_frame_props
  import adc_frame_pkg::*;
(
  input wire logic                core_clk,
  input wire logic                reset_n,
  input wire logic                cs_n,
  input wire logic                sdo_out,
  input wire logic                sdo_oe,
  input wire logic                acquiring,
  input wire logic                powered_down,
  input wire logic                frame_mode32,
  input wire logic                conv_abort,
  input wire logic [RESULT_W-1:0] last_result
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence cs_long_high;
    cs_n[*8] ##1 cs_n[*4];
  endsequence

  sequence cs_held_low;
    !cs_n ##1 !cs_n;
  endsequence

  chk_oe_follows_cs: assert property (sdo_oe == !cs_n)
    else $error("data enable does not follow chip select");
  chk_sdo_idle_zero: assert property (cs_n |-> !sdo_out)
    else $error("serial data not parked while deselected");
  chk_mode_frozen: assert property (cs_held_low |-> $stable(frame_mode32))
    else $error("framing mode changed inside a frame");
  chk_result_frozen: assert property (cs_held_low |-> $stable(last_result))
    else $error("result changed inside a frame");
  chk_abort_single: assert property (conv_abort |=> !conv_abort)
    else $error("abort pulse longer than one cycle");
  chk_abort_after_rise: assert property (conv_abort |-> cs_n && $past(cs_n, 3))
    else $error("abort without a chip select rise");
  chk_abort_no_result: assert property (conv_abort |->
      ($stable(last_result) && $stable(frame_mode32))[*3])
    else $error("abort updated result or mode");
  chk_acq_after_abort: assert property (conv_abort |-> ##[0:2] acquiring)
    else $error("no acquisition after abort");
  chk_acq_ends_fall: assert property ($fell(cs_n) |-> ##[1:6] !acquiring)
    else $error("acquisition not ended by chip select fall");
  chk_acq_in_idle: assert property (cs_long_high |-> acquiring || powered_down)
    else $error("not acquiring while deselected");
  chk_pd_enter_low: assert property ($rose(powered_down) |-> !cs_n)
    else $error("power-down entered outside a frame");
  chk_pd_leave_high: assert property ($fell(powered_down) |-> cs_n)
    else $error("power-down left inside a frame");
endmodule

// ---- sim/adc_host_model.sv ----
`timescale 1ns/10ps
module adc_host_model (
  output logic      cs_n,
  output logic      link_sclk,
  output logic      input_channel_select,
  output logic      powerdown_request_pin,
  input  wire logic sdo_out
);
  logic [31:0] cap;
  event        got;

  initial begin
    cs_n = 1'b1;
    link_sclk = 1'b0;
    input_channel_select = 1'b0;
    powerdown_request_pin = 1'b0;
    cap = 32'h0;
  end

  // serial clock runs only inside a frame, 160 ns period, bits taken at rises
  task automatic frame(input int n, input logic ch, input logic pd);
    #1.3 cs_n = 1'b0;
    cap = 32'h0;
    #80;
    for (int i = 1; i <= n; i++) begin
      link_sclk = 1'b1;
      cap = {cap[30:0], sdo_out};
      #80 link_sclk = 1'b0;
      if (i == 1) input_channel_select = ch;
      #80;
    end
    powerdown_request_pin = pd;
    #40 cs_n = 1'b1;
    -> got;
    #40 powerdown_request_pin = 1'b0;
    #160;
  endtask
endmodule

// ---- sim/sar_adc_serial_frame_control_tb_top.sv ----
`timescale 1ns/10ps
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin err_count++; \
  $display("BAD %s exp %h seen %h", nm, e, s); end end
module sar_adc_serial_frame_control_tb_top import adc_frame_pkg::*;;
  typedef struct {logic [31:0] w; logic ok; logic [RESULT_W-1:0] r; logic m; logic p;
                  logic a;} note_t;
  logic                core_clk = 1'b0;
  logic                reset_n = 1'b0;
  logic [RESULT_W-1:0] ch0_code, ch1_code, last_result, prev;
  logic                cs_n, link_sclk, input_channel_select, powerdown_request_pin;
  logic                sdo_out, sdo_oe, acquiring, powered_down, frame_mode32, conv_abort;
  logic                mode, inv, pwr, pdarm;
  logic [18:0]         rst_seen;
  int                  err_count, comparisons, cycles, ab;
  note_t               notes[$];
  note_t               e;
  int                  sweep[7] = '{32, 16, 30, 29, 32, 32, 20};
  int                  abrt[6] = '{8, 16, 16, 1, 16, 16};

  adc_frame_ctrl DUT (.core_clk(core_clk), .reset_n(reset_n), .link_sclk(link_sclk),
    .cs_n(cs_n), .input_channel_select(input_channel_select),
    .powerdown_request_pin(powerdown_request_pin), .ch0_code(ch0_code), .ch1_code(ch1_code),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe), .acquiring(acquiring), .powered_down(powered_down),
    .frame_mode32(frame_mode32), .conv_abort(conv_abort), .last_result(last_result));

  adc_host_model host (.cs_n(cs_n), .link_sclk(link_sclk),
    .input_channel_select(input_channel_select),
    .powerdown_request_pin(powerdown_request_pin), .sdo_out(sdo_out));

  always #2 core_clk = ~core_clk;

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      finish_test();
    end
  end

  // one frame: fresh codes, expected word noted before the host runs it
  task automatic run(input int n, input logic pd);
    logic [31:0]         full;
    logic [RESULT_W-1:0] smp;
    logic                ok;
    logic                pin;
    @(posedge core_clk);
    ch0_code <= RESULT_W'($urandom);
    ch1_code <= RESULT_W'($urandom);
    repeat (3) @(posedge core_clk);
    smp = input_channel_select ? ch1_code : ch0_code;
    full = {mode ? 16'h0000 : {prev, 2'b00}, smp, 2'b00};
    ok = !inv;
    inv = (n < 16);
    if (!inv) begin
      prev = smp;
      mode = (n >= 30);
    end
    // armed by the previous rise, entered at fall 16, left at a rise without request
    pin = pwr | (pdarm & (n >= 16));
    pwr = pd & pin;
    pdarm = pd;
    notes.push_back('{full >> (32 - n), ok, prev, mode, pin, (n < 16)});
    host.frame(n, 1'($urandom), pd);
  endtask

  initial forever begin
    @(host.got);
    e = notes.pop_front();
    if (e.ok) `CHK("frame bits", e.w, host.cap)
    `CHK("power-down", e.p, powered_down)
    ab = 0;
    repeat (12) begin
      @(negedge core_clk);
      if (conv_abort === 1'b1) ab++;
    end
    `CHK("abort pulses", int'(e.a), ab)
    `CHK("acquiring", 1'b1, acquiring)
    `CHK("data enable", 1'b0, sdo_oe)
    `CHK("last result", e.r, last_result)
    `CHK("framing mode", e.m, frame_mode32)
  end

  initial begin
    void'($urandom(69));
    ch0_code = 14'h0000;
    ch1_code = 14'h0000;
    prev = 14'h0000;
    mode = 1'b0;
    inv = 1'b0;
    pwr = 1'b0;
    pdarm = 1'b0;
    repeat (6) @(posedge core_clk);
    rst_seen = {acquiring, powered_down, frame_mode32, conv_abort, sdo_oe, last_result};
    `CHK("reset state", 19'h40000, rst_seen)
    reset_n <= 1'b1;
    $display("test reset done");
    repeat (4) run(16, 1'b0);
    $display("test frame16 done");
    foreach (sweep[i]) run(sweep[i], 1'b0);
    $display("test mode sweep done");
    foreach (abrt[i]) run(abrt[i], 1'b0);
    $display("test abort done");
    run(16, 1'b1);
    run(16, 1'b0);
    run(32, 1'b1);
    run(16, 1'b0);
    $display("test power-down done");
    finish_test();
  end
endmodule

bind adc_frame_ctrl adc_frame_props u_props (.core_clk(core_clk), .reset_n(reset_n),
  .cs_n(cs_n), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .acquiring(acquiring),
  .powered_down(powered_down), .frame_mode32(frame_mode32), .conv_abort(conv_abort),
  .last_result(last_result));
